// [pmm_pkg.sv]
// What this block does
// RULE_01 - 100M transmit error sends HALT; 10M ignores it
// RULE_02 - Coder bypassed: transmit error is data bit four
// RULE_03 - Nibble transmit data; serial uses bit zero only
// RULE_04 - MAC holds enable exactly over valid data
// RULE_05 - Transmit clock 25, 2.5 or 10 MHz
// RULE_06 - Receive clock at same mode rates
// RULE_07 - Management clock no faster than 2.5 MHz
// RULE_08 - Receive nibbles on receive clock; serial bit zero
// RULE_09 - Interrupt low on link, speed, duplex change
// RULE_10 - Carrier sense: node half-duplex includes transmit
// RULE_11 - Carrier pin strap selects coder bypass
// RULE_12 - Collision in half-duplex only, else zero
// RULE_13 - Receive valid exactly while data valid
// RULE_14 - Receive error on bad group; bypass bit four
// RULE_15 - Receive error pin strap selects repeater role
// RULE_16 - Low output enable floats receive outputs; rx_er_o stays driven outside reset
// RULE_17 - Low reset initializes; straps latched at reset
// RULE_18 - Management frames follow clause 22 with turnaround
//
// Purpose: Shared constants and carriers for the MII port of a 10/100 transceiver.
// Assumes: Core clock of 100 MHz; all pins sampled synchronously to it.
// Notes: Register offsets are word indices on a plain 16-bit register port.
`default_nettype none
package pmm_pkg;
    // Core clock period
    localparam int CLK_NS = 10;
    // Link clock periods in ns, per mode
    localparam int PER_100_NS = 40;
    localparam int PER_10S_NS = 100;
    localparam int PER_10N_NS = 400;
    // Half periods in core cycles
    localparam logic [4:0] HALF_100 = 5'((PER_100_NS / CLK_NS) / 2);
    localparam logic [4:0] HALF_10S = 5'((PER_10S_NS / CLK_NS) / 2);
    localparam logic [4:0] HALF_10N = 5'((PER_10N_NS / CLK_NS) / 2);
    // HALT code group substituted on transmit error
    localparam logic [4:0] HALT_CODE = 5'h04;
    // Management frame figures
    localparam logic [5:0] MD_PRE_LEN = 6'h20;
    localparam logic [5:0] MD_HDR_LAST = 6'h0d;
    localparam logic [5:0] MD_DATA_LAST = 6'h0f;
    localparam logic [1:0] MD_OP_RD = 2'h2;
    localparam logic [1:0] MD_OP_WR = 2'h1;
    // Register indices
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h1;
    localparam logic [3:0] REG_IRQ_STAT = 4'h2;
    localparam logic [3:0] REG_IRQ_CLR = 4'h3;
    localparam logic [3:0] REG_IRQ_EN = 4'h4;
    // Control fields
    localparam int CTRL_SPEED100 = 0;
    localparam int CTRL_SERIAL = 1;
    localparam int CTRL_FDX = 2;
    localparam logic [2:0] CTRL_RST = 3'h1;
    // Interrupt fields
    localparam int IRQ_LINK = 0;
    localparam int IRQ_SPEED = 1;
    localparam int IRQ_DUPLEX = 2;
    localparam logic [2:0] IRQ_EN_RST = 3'h7;
    // Management state machine
    typedef enum logic [2:0] {
        PMM_MD_IDLE = 3'b000,
        PMM_MD_HDR = 3'b001,
        PMM_MD_TA = 3'b010,
        PMM_MD_RD = 3'b011,
        PMM_MD_WR = 3'b100
    } pmm_md_state_t;
    // Code group handed to the transmit coder
    typedef struct packed {
        logic valid;
        logic raw;
        logic [4:0] data;
    } pmm_tx_sym_t;
    // Code group from the receive decoder
    typedef struct packed {
        logic carrier;
        logic valid;
        logic err;
        logic [4:0] data;
    } pmm_rx_sym_t;
endpackage
`default_nettype wire

// [pmm_mii_port.sv]
// Purpose: MAC-facing MII port: clocks, data paths, carrier, collision, straps,
//          management slave and status interrupt.
// Assumes: All pins synchronous to core_clk; management clock slow against it.
// Notes: Two-way pins are split into input, output and output enable.
`timescale 1ns/1ps
`default_nettype none
module pmm_mii_port (
    // Clock and resets
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic phy_reset_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // MAC transmit
    input wire logic [3:0] txd,
    input wire logic tx_en,
    input wire logic tx_er,
    output logic tx_clk,
    // MAC receive
    output logic [3:0] rxd,
    output logic rx_dv,
    output logic rx_clk,
    output logic rx_oe,
    input wire logic rx_outputs_enable,
    input wire logic rx_er_i,
    output logic rx_er_o,
    output logic rx_er_oe,
    // Carrier and collision
    input wire logic crs_i,
    output logic crs_o,
    output logic crs_oe,
    output logic col,
    // Management
    input wire logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe,
    input wire logic [4:0] phy_addr,
    output logic status_change_irq_n,
    // Coder side
    output pmm_pkg::pmm_tx_sym_t tx_sym,
    input wire pmm_pkg::pmm_rx_sym_t rx_sym,
    input wire logic link_ok
);
    import pmm_pkg::*;

    // Register read decode, shared by the port and the management slave
    function automatic logic [15:0] reg_read(input logic [3:0] a, input logic [2:0] ctrl,
                                             input logic [6:0] stat, input logic [2:0] ist,
                                             input logic [2:0] ien);
        logic [15:0] r;
        r = 16'h0000;
        case (a)
            REG_CTRL: r = {13'h0000, ctrl};
            REG_STAT: r = {9'h000, stat};
            REG_IRQ_STAT: r = {13'h0000, ist};
            REG_IRQ_EN: r = {13'h0000, ien};
            default: r = 16'h0000;
        endcase
        return r;
    endfunction

    // Either reset source initializes everything
    logic rst;
    assign rst = sys_rst | ~phy_reset_n; // RULE_17

    // Software state
    logic [2:0] ctrl_reg, ctrl_next;
    logic [2:0] irq_stat_reg, irq_stat_next;
    logic [2:0] irq_en_reg, irq_en_next;
    logic [15:0] reg_rdata_next;
    // Latched straps
    logic bypass_reg;
    logic repeater_reg;
    // Previous status for change detection
    logic link_q_reg;
    logic [2:0] ctrl_q_reg;
    // Link clock divider
    logic [4:0] div_reg, div_next;
    logic lclk_reg;
    logic [4:0] half_sel;
    logic div_wrap;
    logic rise_tick;
    logic fall_tick;
    // Transmit sample
    logic tx_active_reg;
    pmm_tx_sym_t tx_sym_next;
    // Receive outputs
    logic [3:0] rxd_next;
    logic rx_er_next;
    // Management slave
    pmm_md_state_t md_state_reg, md_state_next;
    logic [5:0] md_cnt_reg, md_cnt_next;
    logic [15:0] md_sh_reg, md_sh_next;
    logic [3:0] md_addr_reg, md_addr_next;
    logic md_rd_reg, md_rd_next;
    logic mdio_o_next, mdio_oe_next;
    logic md_wr_next;
    logic mdc_q_reg;
    logic mdc_rise;
    logic [12:0] md_hdr;
    // Shared write path
    logic wr_any;
    logic [3:0] wr_addr;
    logic [15:0] wr_data;
    logic [6:0] stat_word;
    logic [2:0] events;

    // Mode fields
    logic speed100, serial10, fdx;
    assign speed100 = ctrl_reg[CTRL_SPEED100];
    assign serial10 = ctrl_reg[CTRL_SERIAL] & ~speed100;
    assign fdx = ctrl_reg[CTRL_FDX];

    // Straps caught while reset is held; pins are released then
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bypass_reg <= crs_i; // RULE_11
            repeater_reg <= rx_er_i; // RULE_15
        end
    end

    // Link clock rate per mode; receive clock derived from the same reference
    assign half_sel = speed100 ? HALF_100 : (serial10 ? HALF_10S : HALF_10N); // RULE_05 RULE_06
    assign div_wrap = (div_reg >= half_sel - 5'h01);
    assign div_next = div_wrap ? 5'h00 : div_reg + 5'h01;
    assign rise_tick = div_wrap & ~lclk_reg;
    assign fall_tick = div_wrap & lclk_reg;

    // Divider and clock flip-flop
    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_reg <= 5'h00;
            lclk_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            if (div_wrap) begin
                lclk_reg <= ~lclk_reg;
            end
        end
    end
    assign tx_clk = lclk_reg; // RULE_05
    assign rx_clk = lclk_reg; // RULE_06

    // Transmit code group: HALT, raw five bits, nibble or serial bit
    always_comb begin
        tx_sym_next.valid = tx_en; // RULE_04
        tx_sym_next.raw = bypass_reg;
        tx_sym_next.data = {1'b0, txd};
        if (bypass_reg) begin
            tx_sym_next.data = {tx_er, txd}; // RULE_02
        end else if (speed100 && tx_en && tx_er) begin
            tx_sym_next.raw = 1'b1;
            tx_sym_next.data = HALT_CODE; // RULE_01
        end else if (serial10) begin
            tx_sym_next.data = {4'h0, txd[0]}; // RULE_03
        end
    end

    // Sample the MAC at each rising link clock edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_sym <= '0;
            tx_active_reg <= 1'b0;
        end else if (rise_tick) begin
            tx_sym <= tx_sym_next; // RULE_03
            tx_active_reg <= tx_en; // RULE_04
        end
    end

    // Receive data: serial mode keeps only bit zero, others read low
    assign rxd_next = serial10 ? {3'h0, rx_sym.data[0]} : rx_sym.data[3:0]; // RULE_08
    assign rx_er_next = bypass_reg ? rx_sym.data[4] : (rx_sym.valid & rx_sym.err); // RULE_14

    // Receive outputs change on the falling edge so the MAC samples them stable
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rxd <= 4'h0;
            rx_dv <= 1'b0;
            rx_er_o <= 1'b0;
        end else if (fall_tick) begin
            rxd <= rx_sym.valid ? rxd_next : 4'h0; // RULE_08
            rx_dv <= rx_sym.valid; // RULE_13
            rx_er_o <= rx_er_next; // RULE_14
        end
    end

    // Receive group except rx_er_o floats when disabled; strap pins float during reset
    assign rx_oe = rx_outputs_enable & ~rst; // RULE_16
    assign rx_er_oe = ~rst; // RULE_15
    assign crs_oe = ~rst; // RULE_11

    // Carrier: transmit counts only for a half-duplex node
    assign crs_o = rx_sym.carrier | (tx_active_reg & ~repeater_reg & ~fdx); // RULE_10
    // Collision: both directions busy at half duplex, forced low at full
    assign col = ~fdx & rx_sym.carrier & tx_active_reg; // RULE_12

    // Status word and change events
    assign stat_word = {rx_dv, tx_active_reg, col, crs_o, repeater_reg, bypass_reg, link_ok};
    assign events[IRQ_LINK] = link_q_reg ^ link_ok; // RULE_09
    assign events[IRQ_SPEED] = ctrl_q_reg[CTRL_SPEED100] ^ ctrl_reg[CTRL_SPEED100]; // RULE_09
    assign events[IRQ_DUPLEX] = ctrl_q_reg[CTRL_FDX] ^ ctrl_reg[CTRL_FDX]; // RULE_09

    // Port write wins over a management write in the same cycle
    assign wr_any = reg_wr | md_wr_next;
    assign wr_addr = reg_wr ? reg_addr : md_addr_reg;
    assign wr_data = reg_wr ? reg_wdata : {md_sh_reg[14:0], mdio_i};

    // Next values of software registers; a new event beats a clear
    assign ctrl_next = (wr_any && wr_addr == REG_CTRL) ? wr_data[2:0] : ctrl_reg;
    assign irq_en_next = (wr_any && wr_addr == REG_IRQ_EN) ? wr_data[2:0] : irq_en_reg;
    assign irq_stat_next = (irq_stat_reg & ~((wr_any && wr_addr == REG_IRQ_CLR) ? wr_data[2:0] : 3'h0))
                           | events;
    assign reg_rdata_next = reg_rd ? reg_read(reg_addr, ctrl_reg, stat_word, irq_stat_reg, irq_en_reg)
                                   : 16'h0000;

    // Register file
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_reg <= CTRL_RST;
            irq_en_reg <= IRQ_EN_RST;
            irq_stat_reg <= 3'h0;
            ctrl_q_reg <= CTRL_RST;
            link_q_reg <= 1'b0;
            reg_rdata <= 16'h0000;
        end else begin
            ctrl_reg <= ctrl_next;
            irq_en_reg <= irq_en_next;
            irq_stat_reg <= irq_stat_next;
            ctrl_q_reg <= ctrl_reg;
            link_q_reg <= link_ok;
            reg_rdata <= reg_rdata_next;
        end
    end

    // Level interrupt, active low while an enabled status bit stands
    assign status_change_irq_n = ~|(irq_stat_reg & irq_en_reg); // RULE_09

    // Management clock edge; the entity keeps it slow enough to see every edge
    assign mdc_rise = mdc & ~mdc_q_reg; // RULE_07
    assign md_hdr = {md_sh_reg[11:0], mdio_i};

    // Management frame slave: preamble, header, turnaround, data
    always_comb begin
        md_state_next = md_state_reg;
        md_cnt_next = md_cnt_reg;
        md_sh_next = md_sh_reg;
        md_addr_next = md_addr_reg;
        md_rd_next = md_rd_reg;
        mdio_o_next = mdio_o;
        mdio_oe_next = mdio_oe;
        md_wr_next = 1'b0;
        if (mdc_rise) begin
            case (md_state_reg)
                PMM_MD_IDLE: begin
                    // Count ones; a zero after a full preamble is the start bit
                    if (mdio_i) begin
                        md_cnt_next = (md_cnt_reg == MD_PRE_LEN) ? md_cnt_reg : md_cnt_reg + 6'h01;
                    end else if (md_cnt_reg == MD_PRE_LEN) begin
                        md_state_next = PMM_MD_HDR; // RULE_18
                        md_cnt_next = 6'h01;
                        md_sh_next = 16'h0000;
                    end else begin
                        md_cnt_next = 6'h00;
                    end
                end
                PMM_MD_HDR: begin
                    md_sh_next = {md_sh_reg[14:0], mdio_i};
                    md_cnt_next = md_cnt_reg + 6'h01;
                    if (md_cnt_reg == MD_HDR_LAST) begin
                        // Start bit, opcode and address must all match
                        md_cnt_next = 6'h00;
                        md_addr_next = md_hdr[3:0];
                        md_rd_next = (md_hdr[11:10] == MD_OP_RD);
                        md_sh_next = reg_read(md_hdr[3:0], ctrl_reg, stat_word, irq_stat_reg, irq_en_reg);
                        if (md_hdr[12] && md_hdr[9:5] == phy_addr && md_hdr[4] == 1'b0
                            && (md_hdr[11:10] == MD_OP_RD || md_hdr[11:10] == MD_OP_WR)) begin
                            md_state_next = PMM_MD_TA; // RULE_18
                        end else begin
                            md_state_next = PMM_MD_IDLE;
                        end
                    end
                end
                PMM_MD_TA: begin
                    // Second turnaround bit is a driven zero on reads
                    md_cnt_next = md_cnt_reg + 6'h01;
                    if (md_cnt_reg == 6'h00) begin
                        mdio_oe_next = md_rd_reg; // RULE_18
                        mdio_o_next = 1'b0;
                    end else begin
                        md_cnt_next = 6'h00;
                        md_state_next = md_rd_reg ? PMM_MD_RD : PMM_MD_WR;
                        if (md_rd_reg) begin
                            mdio_o_next = md_sh_reg[15];
                            md_sh_next = {md_sh_reg[14:0], 1'b0};
                        end
                    end
                end
                PMM_MD_RD: begin
                    // Shift read data out, then release the pin
                    md_cnt_next = md_cnt_reg + 6'h01;
                    mdio_o_next = md_sh_reg[15];
                    md_sh_next = {md_sh_reg[14:0], 1'b0};
                    if (md_cnt_reg == MD_DATA_LAST) begin
                        mdio_oe_next = 1'b0; // RULE_18
                        mdio_o_next = 1'b0;
                        md_cnt_next = 6'h00;
                        md_state_next = PMM_MD_IDLE;
                    end
                end
                PMM_MD_WR: begin
                    // Collect write data; the last bit writes the register
                    md_cnt_next = md_cnt_reg + 6'h01;
                    md_sh_next = {md_sh_reg[14:0], mdio_i};
                    if (md_cnt_reg == MD_DATA_LAST) begin
                        md_wr_next = 1'b1;
                        md_cnt_next = 6'h00;
                        md_state_next = PMM_MD_IDLE;
                    end
                end
                default: begin
                    md_state_next = PMM_MD_IDLE;
                    md_cnt_next = 6'h00;
                    mdio_oe_next = 1'b0;
                end
            endcase
        end
    end

    // Management state flip-flops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            md_state_reg <= PMM_MD_IDLE;
            md_cnt_reg <= 6'h00;
            md_sh_reg <= 16'h0000;
            md_addr_reg <= 4'h0;
            md_rd_reg <= 1'b0;
            mdio_o <= 1'b0;
            mdio_oe <= 1'b0;
            mdc_q_reg <= 1'b0;
        end else begin
            md_state_reg <= md_state_next;
            md_cnt_reg <= md_cnt_next;
            md_sh_reg <= md_sh_next;
            md_addr_reg <= md_addr_next;
            md_rd_reg <= md_rd_next;
            mdio_o <= mdio_o_next;
            mdio_oe <= mdio_oe_next;
            mdc_q_reg <= mdc;
        end
    end
endmodule // pmm_mii_port
`default_nettype wire

// [pmm_mii_props.sv]
// Purpose: Port assertions for the MII port.
// Assumes: One clock; sys_rst and phy_reset_n both reset the port.
// Notes: The bypass strap is copied from the carrier pin during reset.
`timescale 1ns/1ps
`default_nettype none
module pmm_mii_props (
    // Clock and resets
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic phy_reset_n,
    // Register port
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Transmit side
    input wire logic [3:0] txd,
    input wire logic tx_en,
    input wire logic tx_er,
    input wire logic tx_clk,
    input wire pmm_pkg::pmm_tx_sym_t tx_sym,
    // Receive side
    input wire logic rx_clk,
    input wire logic [3:0] rxd,
    input wire logic rx_dv,
    input wire logic rx_oe,
    input wire logic rx_outputs_enable,
    input wire logic crs_i,
    input wire logic crs_o,
    input wire logic col
);
    import pmm_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst || !phy_reset_n);
    logic byp_seen; // Bypass strap copy
    always @(posedge core_clk) if (sys_rst || !phy_reset_n) byp_seen <= crs_i;
    // Reset must be seen through, so this one is never disabled
    a_rst_quiet: assert property (disable iff (1'b0) (sys_rst || !phy_reset_n) |=>
        !tx_clk && !rx_dv && reg_rdata == 16'h0000) else $error("outputs not cleared in reset");
    // Transmit group taken at the wrap, one edge before the rise
    a_tx_valid: assert property ($rose(tx_clk) |-> tx_sym.valid == $past(tx_en))
        else $error("tx valid does not follow enable");
    a_bypass_data: assert property ($rose(tx_clk) && byp_seen && tx_sym.valid |->
        tx_sym.raw && tx_sym.data == {$past(tx_er), $past(txd)}) else $error("bypass group wrong");
    a_rxd_quiet: assert property (!rx_dv |-> rxd == 4'h0) else $error("rxd set without valid");
    a_rx_enable: assert property (rx_oe == rx_outputs_enable) else $error("rx enable wrong");
    a_clk_pair: assert property (rx_clk == tx_clk) else $error("rx clock differs");
    // Mode switches may stretch one phase, hence the loose upper bound
    a_clk_phase: assert property ($rose(tx_clk) |-> tx_clk [*2] ##[1:40] !tx_clk)
        else $error("tx clock phase wrong");
    a_col_crs: assert property (col |-> crs_o) else $error("collision without carrier");
    a_rd_answer: assert property (reg_rdata != 16'h0000 |-> $past(reg_rd)) else $error("stray read data");
endmodule // pmm_mii_props
bind pmm_mii_port pmm_mii_props i_props (.core_clk(core_clk), .sys_rst(sys_rst),
    .phy_reset_n(phy_reset_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txd(txd), .tx_en(tx_en),
    .tx_er(tx_er), .tx_clk(tx_clk), .tx_sym(tx_sym), .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv),
    .rx_oe(rx_oe), .rx_outputs_enable(rx_outputs_enable), .crs_i(crs_i), .crs_o(crs_o), .col(col));
`default_nettype wire

// [pmm_mac_model.sv]
// Purpose: MAC transmit side that feeds the port one beat per link clock.
// Assumes: Link clock sampled on core_clk; bench supplies the next beat.
// Notes: Idle data toggles so a stale nibble never looks valid.
`timescale 1ns/1ps
`default_nettype none
module pmm_mac_model (
    // Clocks
    input wire logic core_clk,
    input wire logic tx_clk,
    // Next beat
    input wire logic [3:0] nib,
    input wire logic er,
    input wire logic en,
    // MAC pins
    output logic [3:0] txd = 4'h0,
    output logic tx_en = 1'b0,
    output logic tx_er = 1'b0
);
    logic clk_q = 1'b0; // Link clock one core cycle ago
    // Change only just after a link clock rise, held a full period
    always @(posedge core_clk) begin
        clk_q <= tx_clk;
        if (tx_clk && !clk_q) begin
            tx_en <= en;
            txd <= en ? nib : ~txd;
            tx_er <= er;
        end
    end
endmodule // pmm_mac_model
`default_nettype wire

// [pmm_mii_port_test.sv]
// Purpose: Self-checking bench for the MII port.
// Assumes: 100 MHz core clock; the MAC model drives transmit pins.
// Notes: Strap pins resolved here.
`timescale 1ns/1ps
`default_nettype none
module pmm_mii_port_test;
    import pmm_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1, phy_reset_n = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0, b_nib = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic b_er = 1'b0, b_en = 1'b0, rx_outputs_enable = 1'b1, link_ok = 1'b0;
    logic crs_strap = 1'b0, role_strap = 1'b0; // Pull levels on the strap pins
    logic mdc = 1'b0, mdio = 1'b1, mdio_o, mdio_oe; // Management pins
    pmm_rx_sym_t rx_sym = '0;
    logic [15:0] reg_rdata;
    logic [3:0] txd, rxd;
    logic tx_en, tx_er, tx_clk, rx_dv, rx_clk, rx_oe, rx_er_o, rx_er_oe, crs_o, crs_oe, col, irq_n;
    pmm_tx_sym_t tx_sym;
    int num_errors = 0, samples_checked = 0;
    // Pin level: device when driving, else the strap pull
    wire logic crs_pin = crs_oe ? crs_o : crs_strap;
    wire logic rxer_pin = rx_er_oe ? rx_er_o : role_strap;
    always #5 core_clk = ~core_clk;
    pmm_mac_model i_mac (.core_clk(core_clk), .tx_clk(tx_clk), .nib(b_nib), .er(b_er), .en(b_en),
        .txd(txd), .tx_en(tx_en), .tx_er(tx_er));
    pmm_mii_port i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .phy_reset_n(phy_reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .txd(txd), .tx_en(tx_en), .tx_er(tx_er), .tx_clk(tx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_clk(rx_clk),
        .rx_oe(rx_oe), .rx_outputs_enable(rx_outputs_enable), .rx_er_i(rxer_pin), .rx_er_o(rx_er_o),
        .rx_er_oe(rx_er_oe), .crs_i(crs_pin), .crs_o(crs_o), .crs_oe(crs_oe), .col(col),
        .mdc(mdc), .mdio_i(mdio), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .phy_addr(5'h01),
        .status_change_irq_n(irq_n), .tx_sym(tx_sym), .rx_sym(rx_sym), .link_ok(link_ok));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", exp, reg_rdata);
    endtask
    // Two link rises: model takes the beat, port loads it
    task automatic settle();
        repeat (2) @(posedge tx_clk);
        #1;
    endtask
    task automatic beat(input logic [3:0] n, input logic e, input logic v);
        @(posedge tx_clk);
        b_nib <= n;
        b_er <= e;
        b_en <= v;
        settle();
    endtask
    task automatic per(input int exp);
        time t0;
        settle();
        @(posedge tx_clk);
        t0 = $time;
        @(posedge tx_clk);
        chk("tx_clk period", 16'(exp), 16'(($time - t0) / CLK_NS));
    endtask
    task automatic strap_reset(input logic c, input logic r);
        @(posedge core_clk);
        crs_strap <= c;
        role_strap <= r;
        phy_reset_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        phy_reset_n <= 1'b1;
    endtask
    // One management bit, 400 ns per bit
    task automatic md_bit(input logic b);
        mdio <= b;
        repeat (20) @(posedge core_clk);
        mdc <= 1'b1;
        repeat (20) @(posedge core_clk);
        mdc <= 1'b0;
    endtask
    // Read frame; turnaround and data slots stay pulled up
    task automatic md_read(input logic [3:0] a, input logic [15:0] exp);
        logic [13:0] hdr = {2'b01, MD_OP_RD, 5'h01, 1'b0, a};
        logic [15:0] got;
        repeat (32) md_bit(1'b1);
        for (int i = 13; i >= 0; i--) md_bit(hdr[i]);
        repeat (2) md_bit(1'b1);
        for (int i = 0; i < 16; i++) begin
            got = {got[14:0], mdio_o};
            md_bit(1'b1);
        end
        chk("mdio read", exp, got);
        chk("mdio_oe", 16'h0000, {15'h0, mdio_oe});
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Cut a hang short; the whole run needs well under this
    initial begin
        #500000;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(REG_CTRL, {13'h0, CTRL_RST});
        rd(REG_IRQ_EN, {13'h0, IRQ_EN_RST});
        rd(4'hf, 16'h0000);
        $display("test reset done");
        @(posedge core_clk);
        link_ok <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1 chk("irq_n", 16'h0000, {15'h0, irq_n});
        rd(REG_IRQ_STAT, 16'h0001);
        wr(REG_IRQ_EN, 16'h0000);
        #1 chk("irq_n masked", 16'h0001, {15'h0, irq_n});
        wr(REG_IRQ_CLR, 16'h0007);
        rd(REG_IRQ_STAT, 16'h0000);
        wr(REG_IRQ_EN, 16'h0007);
        wr(REG_CTRL, 16'h0000);
        repeat (3) @(posedge core_clk);
        rd(REG_IRQ_STAT, 16'h0002);
        wr(REG_IRQ_CLR, 16'h0007);
        $display("test interrupt done");
        per(PER_10N_NS / CLK_NS);
        beat(4'h6, 1'b1, 1'b1);
        chk("tx_sym", 16'h0046, {9'h0, tx_sym});
        wr(REG_CTRL, 16'h0002);
        per(PER_10S_NS / CLK_NS);
        beat(4'he, 1'b0, 1'b1);
        chk("tx_sym", 16'h0040, {9'h0, tx_sym});
        beat(4'h7, 1'b0, 1'b1);
        chk("tx_sym", 16'h0041, {9'h0, tx_sym});
        wr(REG_CTRL, 16'h0001);
        per(PER_100_NS / CLK_NS);
        beat(4'ha, 1'b0, 1'b1);
        chk("tx_sym", 16'h004a, {9'h0, tx_sym});
        beat(4'h3, 1'b1, 1'b1);
        chk("tx_sym", {9'h0, 2'b11, HALT_CODE}, {9'h0, tx_sym});
        beat(4'h3, 1'b1, 1'b0);
        chk("tx valid", 16'h0000, {15'h0, tx_sym.valid});
        $display("test transmit done");
        @(posedge core_clk);
        rx_sym <= '{carrier: 1'b1, valid: 1'b1, err: 1'b0, data: 5'h0c};
        settle();
        chk("rx group", 16'h006c, {9'h0, crs_o, rx_dv, rx_er_o, rxd});
        @(posedge core_clk);
        rx_sym.err <= 1'b1;
        settle();
        chk("rx group", 16'h007c, {9'h0, crs_o, rx_dv, rx_er_o, rxd});
        @(posedge core_clk);
        rx_sym <= '{carrier: 1'b0, valid: 1'b0, err: 1'b1, data: 5'h0c};
        settle();
        chk("rx group", 16'h0000, {9'h0, crs_o, rx_dv, rx_er_o, rxd});
        @(posedge core_clk);
        rx_outputs_enable <= 1'b0;
        @(posedge core_clk);
        #1 chk("rx_oe", 16'h0000, {15'h0, rx_oe});
        @(posedge core_clk);
        rx_outputs_enable <= 1'b1;
        $display("test receive done");
        beat(4'h1, 1'b0, 1'b1);
        chk("crs col", 16'h0002, {14'h0, crs_o, col});
        @(posedge core_clk);
        rx_sym.carrier <= 1'b1;
        settle();
        chk("crs col", 16'h0003, {14'h0, crs_o, col});
        wr(REG_CTRL, 16'h0005);
        settle();
        chk("crs col", 16'h0002, {14'h0, crs_o, col});
        @(posedge core_clk);
        rx_sym.carrier <= 1'b0;
        settle();
        chk("crs col", 16'h0000, {14'h0, crs_o, col});
        $display("test carrier done");
        beat(4'h0, 1'b0, 1'b0);
        strap_reset(1'b1, 1'b1);
        rd(REG_STAT, 16'h0007);
        beat(4'h5, 1'b1, 1'b1);
        chk("tx_sym", 16'h0075, {9'h0, tx_sym});
        chk("crs repeater", 16'h0000, {15'h0, crs_o});
        beat(4'h0, 1'b0, 1'b0);
        strap_reset(1'b0, 1'b0);
        md_read(REG_IRQ_EN, {13'h0, IRQ_EN_RST});
        rd(REG_STAT, 16'h0001);
        $display("test strap done");
        end_of_test();
    end
endmodule // pmm_mii_port_test
`default_nettype wire
